// ===== include/ias_pkg.sv
// Shared constants and types for the two-wire acknowledge, status and data block.
// Assumes a single 100 MHz system clock; bus pins arrive unsynchronised.
package ias_pkg;

   // Register map, byte addresses on the local register port
   localparam logic [7:0] OFS_DATA     = 8'hbc;
   localparam logic [7:0] OFS_STATUS   = 8'hbd;
   localparam logic [7:0] OFS_CTRL     = 8'hc0;
   localparam logic [7:0] OFS_OWN      = 8'hc1;
   localparam logic [7:0] OFS_IRQ_STAT = 8'hc2;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hc3;

   // Control register fields
   localparam int CTRL_AA_BIT  = 2;
   localparam int CTRL_EVT_BIT = 3;
   localparam int CTRL_REL_BIT = 4;
   localparam int CTRL_EN_BIT  = 6;

   // Reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] OWN_RST  = 8'h00;
   localparam logic       PIN_IDLE = 1'b1;

   // Status codes, only bits 7:3 are stored
   localparam int         STAT_LSB_W    = 3;
   localparam logic [7:0] ST_BUS_ERR    = 8'h00;
   localparam logic [7:0] ST_SLA_W      = 8'h60;
   localparam logic [7:0] ST_GC         = 8'h70;
   localparam logic [7:0] ST_RX_ACK     = 8'h80;
   localparam logic [7:0] ST_RX_NACK    = 8'h88;
   localparam logic [7:0] ST_GC_RX_ACK  = 8'h90;
   localparam logic [7:0] ST_GC_RX_NACK = 8'h98;
   localparam logic [7:0] ST_STOP       = 8'ha0;
   localparam logic [7:0] ST_SLA_R      = 8'ha8;
   localparam logic [7:0] ST_TX_ACK     = 8'hb8;
   localparam logic [7:0] ST_TX_NACK    = 8'hc0;
   localparam logic [7:0] ST_TX_LAST    = 8'hc8;
   localparam logic [7:0] ST_IDLE       = 8'hf8;

   // Address matching and byte framing
   localparam logic [6:0] GC_ADDR   = 7'h00;
   localparam logic [3:0] BITS_FULL = 4'h8;

   // Interrupt status and mask fields
   localparam int         IRQ_W       = 3;
   localparam int         IRQ_EVT_BIT = 0;
   localparam int         IRQ_ERR_BIT = 1;
   localparam int         IRQ_STP_BIT = 2;
   localparam logic [2:0] IRQ_RST     = 3'h0;

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_ADDR_ACK,
      S_RX,
      S_RX_ACK,
      S_TX,
      S_TX_ACK,
      S_IGNORE
   } ias_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ias_reg_req_t;

endpackage

// ===== rtl/ias_pin_sync.sv
// Three-stage synchroniser with edge pulses for one bus pin.
// Assumes the pin is asynchronous to i_clock; level changes once stages 2 and 3 agree.
`timescale 1ns/100ps
module ias_pin_sync (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_resetn,
   // Raw pin
   input  wire logic i_pin,
   // Filtered level and one-cycle edge pulses
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   import ias_pkg::*;

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic rise_ff;
   logic fall_ff;
   wire  agree     = (s2_ff == s3_ff);
   wire  nxt_level = agree ? s3_ff : level_ff;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_ff    <= PIN_IDLE;
         s2_ff    <= PIN_IDLE;
         s3_ff    <= PIN_IDLE;
         level_ff <= PIN_IDLE;
         rise_ff  <= 1'b0;
         fall_ff  <= 1'b0;
      end else begin
         s1_ff    <= i_pin;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         level_ff <= nxt_level;
         rise_ff  <= nxt_level & ~level_ff;
         fall_ff  <= ~nxt_level & level_ff;
      end
   end

   assign o_level = level_ff;
   assign o_rise  = rise_ff;
   assign o_fall  = fall_ff;

endmodule // ias_pin_sync

// ===== rtl/ias_slave_core.sv
// Two-wire slave byte engine: acknowledge control, status codes and data register.
// Assumes open-drain SDA/SCL resolved outside; a register port with one-cycle strobes.
`timescale 1ns/100ps
module ias_slave_core (
   // Clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_resetn,
   // Register port
   input  wire ias_pkg::ias_reg_req_t i_reg,
   output logic [7:0]                 o_rdata,
   // Bus pins, output enables active low
   input  wire logic                  i_scl,
   output logic                       o_scl_out,
   output logic                       o_scl_oe_n,
   input  wire logic                  i_sda,
   output logic                       o_sda_out,
   output logic                       o_sda_oe_n,
   // Interrupt
   output logic                       o_irq
);
   import ias_pkg::*;

   function automatic logic [4:0] code5(input logic [7:0] code);
      code5 = code[7:STAT_LSB_W];
   endfunction

   // Synchronised bus
   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic sda_rise;
   logic sda_fall;

   ias_pin_sync u_scl_sync (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_pin    (i_scl),
      .o_level  (scl_lvl),
      .o_rise   (scl_rise),
      .o_fall   (scl_fall)
   );

   ias_pin_sync u_sda_sync (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_pin    (i_sda),
      .o_level  (sda_lvl),
      .o_rise   (sda_rise),
      .o_fall   (sda_fall)
   );

   // State
   ias_state_t       state_ff;
   ias_state_t       nxt_state;
   logic [3:0]       bits_ff;
   logic [3:0]       nxt_bits;
   logic             gc_ff;
   logic             nxt_gc;
   logic             ack_ff;
   logic             nxt_ack;
   logic [4:0]       code_ff;
   logic [4:0]       nxt_code;
   logic             evt_ff;
   logic             aa_ff;
   logic             en_ff;
   logic             rel_ff;
   logic [7:0]       own_ff;
   logic [7:0]       data_ff;
   logic [7:0]       nxt_data;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [7:0]       rdata_ff;
   logic             irq_ff;
   logic             sda_oe_n_ff;
   logic             scl_oe_n_ff;
   logic             pin_low_ff;

   // Engine outputs
   logic       ev_set;
   logic [7:0] ev_code;
   logic       shift_en;
   logic       err_ev;
   logic       stop_ev;

   // Register decode
   wire wr_data  = i_reg.wr && (i_reg.addr == OFS_DATA);
   wire wr_ctrl  = i_reg.wr && (i_reg.addr == OFS_CTRL);
   wire wr_own   = i_reg.wr && (i_reg.addr == OFS_OWN);
   wire wr_istat = i_reg.wr && (i_reg.addr == OFS_IRQ_STAT);
   wire wr_imask = i_reg.wr && (i_reg.addr == OFS_IRQ_MASK);

   wire [7:0] status_rd = {code_ff, {STAT_LSB_W{1'b0}}};
   wire [7:0] ctrl_rd   = {1'b0, en_ff, 1'b0, rel_ff, evt_ff, aa_ff, 2'b00};
   wire [7:0] rd_sel    =
      (i_reg.addr == OFS_DATA)     ? data_ff :
      (i_reg.addr == OFS_STATUS)   ? status_rd :
      (i_reg.addr == OFS_CTRL)     ? ctrl_rd :
      (i_reg.addr == OFS_OWN)      ? own_ff :
      (i_reg.addr == OFS_IRQ_STAT) ? {5'h00, irq_stat_ff} :
      (i_reg.addr == OFS_IRQ_MASK) ? {5'h00, irq_mask_ff} : 8'h00;

   // Bus conditions and address match
   wire start_det  = sda_fall & scl_lvl;
   wire stop_det   = sda_rise & scl_lvl;
   wire in_err     = (code_ff == code5(ST_BUS_ERR));
   wire match_own  = (data_ff[7:1] == own_ff[7:1]);
   wire match_gc   = (data_ff[7:1] == GC_ADDR) && own_ff[0] && !data_ff[0];
   wire byte_done  = scl_fall && (bits_ff == BITS_FULL);
   // The first clock of a byte is also the clock of a STOP or repeated START, so it is legal
   wire mid_byte   = ((state_ff == S_RX) || (state_ff == S_TX)) && (bits_ff > 4'h1);
   wire addr_rx    = (state_ff == S_RX) || (state_ff == S_RX_ACK);

   // Leaving bus error drives nothing onto the bus, it resets the code and clears the event flag
   wire err_exit   = rel_ff && in_err;
   wire evt_clr    = wr_ctrl && !i_reg.wdata[CTRL_EVT_BIT];
   wire idle_state = (state_ff == S_IDLE) || (state_ff == S_IGNORE);
   wire to_idle    = evt_clr && idle_state && !in_err;

   // Byte engine
   always_comb begin
      nxt_state = state_ff;
      nxt_bits  = bits_ff;
      nxt_gc    = gc_ff;
      nxt_ack   = ack_ff;
      ev_set    = 1'b0;
      ev_code   = ST_IDLE;
      shift_en  = 1'b0;
      err_ev    = 1'b0;
      stop_ev   = 1'b0;
      if (!en_ff || in_err) begin
         nxt_state = S_IDLE;
         nxt_bits  = 4'h0;
      end else if (start_det || stop_det) begin
         if (mid_byte) begin
            ev_set  = 1'b1;
            ev_code = ST_BUS_ERR;
            err_ev  = 1'b1;
         end else if (addr_rx) begin
            ev_set  = 1'b1;
            ev_code = ST_STOP;
            stop_ev = 1'b1;
         end
         nxt_state = (start_det && !mid_byte) ? S_ADDR : S_IDLE;
         nxt_bits  = 4'h0;
      end else if (!evt_ff) begin
         case (state_ff)
            S_ADDR: begin
               if (scl_rise) begin
                  shift_en = 1'b1;
                  nxt_bits = bits_ff + 4'h1;
               end else if (byte_done) begin
                  nxt_bits = 4'h0;
                  if (aa_ff && (match_own || match_gc)) begin
                     nxt_state = S_ADDR_ACK;
                     nxt_gc    = match_gc && !match_own;
                  end else begin
                     nxt_state = S_IGNORE;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (scl_fall) begin
                  ev_set    = 1'b1;
                  ev_code   = gc_ff ? ST_GC : (data_ff[0] ? ST_SLA_R : ST_SLA_W);
                  nxt_state = data_ff[0] ? S_TX : S_RX;
               end
            end
            S_RX: begin
               if (scl_rise) begin
                  shift_en = 1'b1;
                  nxt_bits = bits_ff + 4'h1;
               end else if (byte_done) begin
                  nxt_bits  = 4'h0;
                  nxt_ack   = aa_ff;
                  nxt_state = S_RX_ACK;
               end
            end
            S_RX_ACK: begin
               if (scl_fall) begin
                  ev_set = 1'b1;
                  if (ack_ff) begin
                     ev_code   = gc_ff ? ST_GC_RX_ACK : ST_RX_ACK;
                     nxt_state = S_RX;
                  end else begin
                     ev_code   = gc_ff ? ST_GC_RX_NACK : ST_RX_NACK;
                     nxt_state = S_IGNORE;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  shift_en = 1'b1;
                  nxt_bits = bits_ff + 4'h1;
               end else if (byte_done) begin
                  nxt_bits  = 4'h0;
                  nxt_state = S_TX_ACK;
               end
            end
            S_TX_ACK: begin
               if (scl_rise) begin
                  nxt_ack = !sda_lvl;
               end else if (scl_fall) begin
                  ev_set = 1'b1;
                  if (!ack_ff) begin
                     ev_code   = ST_TX_NACK;
                     nxt_state = S_IGNORE;
                  end else if (aa_ff) begin
                     ev_code   = ST_TX_ACK;
                     nxt_state = S_TX;
                  end else begin
                     // Released SDA from here on lets the master read all ones
                     ev_code   = ST_TX_LAST;
                     nxt_state = S_IGNORE;
                  end
               end
            end
            S_IDLE: begin
               nxt_state = S_IDLE;
            end
            S_IGNORE: begin
               nxt_state = S_IGNORE;
            end
            default: begin
               nxt_state = S_IDLE;
            end
         endcase
      end
   end

   // Status code: only the engine, the error exit and a flag clear while idle move it
   always_comb begin
      nxt_code = code_ff;
      if (ev_set) begin
         nxt_code = code5(ev_code);
      end else if (err_exit || to_idle) begin
         nxt_code = code5(ST_IDLE);
      end
   end

   // Data register: bus bits shift in beside the bits going out
   always_comb begin
      nxt_data = data_ff;
      if (shift_en) begin
         nxt_data = {data_ff[6:0], sda_lvl};
      end else if (wr_data) begin
         nxt_data = i_reg.wdata;
      end
   end

   // While enabled, SDA only changes while SCL is low so no false START or STOP is made
   wire drive_low =
      en_ff && ((state_ff == S_ADDR_ACK) ||
                ((state_ff == S_RX_ACK) && ack_ff) ||
                ((state_ff == S_TX) && !data_ff[7]));
   // Disabling releases SDA at once, even in mid clock
   wire nxt_sda_oe_n = (scl_lvl && en_ff) ? sda_oe_n_ff : !drive_low;

   wire nxt_evt = ev_set || (evt_ff && !evt_clr && !err_exit);

   assign nxt_irq_stat = (irq_stat_ff & ~(wr_istat ? i_reg.wdata[IRQ_W-1:0] : IRQ_RST))
                       | {stop_ev, err_ev, ev_set};

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= S_IDLE;
         bits_ff  <= 4'h0;
         gc_ff    <= 1'b0;
         ack_ff   <= 1'b0;
         code_ff  <= code5(ST_IDLE);
         data_ff  <= DATA_RST;
      end else begin
         state_ff <= nxt_state;
         bits_ff  <= nxt_bits;
         gc_ff    <= nxt_gc;
         ack_ff   <= nxt_ack;
         code_ff  <= nxt_code;
         data_ff  <= evt_ff ? (wr_data ? i_reg.wdata : data_ff) : nxt_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         evt_ff <= 1'b0;
         aa_ff  <= 1'b0;
         en_ff  <= 1'b0;
         rel_ff <= 1'b0;
         own_ff <= OWN_RST;
      end else begin
         evt_ff <= nxt_evt;
         aa_ff  <= wr_ctrl ? i_reg.wdata[CTRL_AA_BIT] : aa_ff;
         en_ff  <= wr_ctrl ? i_reg.wdata[CTRL_EN_BIT] : en_ff;
         rel_ff <= (wr_ctrl && i_reg.wdata[CTRL_REL_BIT]) ||
                   (rel_ff && !err_exit && !stop_det);
         own_ff <= wr_own ? i_reg.wdata : own_ff;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_stat_ff <= IRQ_RST;
         irq_mask_ff <= IRQ_RST;
         irq_ff      <= 1'b0;
         rdata_ff    <= 8'h00;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= wr_imask ? i_reg.wdata[IRQ_W-1:0] : irq_mask_ff;
         irq_ff      <= |(nxt_irq_stat & (wr_imask ? i_reg.wdata[IRQ_W-1:0] : irq_mask_ff));
         rdata_ff    <= i_reg.rd ? rd_sel : 8'h00;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         sda_oe_n_ff <= 1'b1;
         scl_oe_n_ff <= 1'b1;
         pin_low_ff  <= 1'b0;
      end else begin
         sda_oe_n_ff <= nxt_sda_oe_n;
         scl_oe_n_ff <= !(nxt_evt && en_ff);
         pin_low_ff  <= 1'b0;
      end
   end

   assign o_rdata    = rdata_ff;
   assign o_irq      = irq_ff;
   assign o_sda_out  = pin_low_ff;
   assign o_sda_oe_n = sda_oe_n_ff;
   assign o_scl_out  = pin_low_ff;
   assign o_scl_oe_n = scl_oe_n_ff;

endmodule // ias_slave_core

// ===== verif/ias_bus_master.sv
// Behavioural two-wire bus master driving pull-down requests.
// Assumes pull-ups resolved by the bench; bus clock of 16 system clocks.
`timescale 1ns/100ps
module ias_bus_master (
   // Clock
   input  wire logic i_clock,
   // Resolved wire levels
   input  wire logic i_scl,
   input  wire logic i_sda,
   // Pull-down requests, high pulls the wire low
   output logic      o_scl_low,
   output logic      o_sda_low
);
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // SDA moves 2 clocks into the low half so it never races the SCL fall
   task automatic bit_x(input logic b, output logic s);
      int n;
      tick(2);
      o_sda_low <= !b;
      tick(6);
      o_scl_low <= 1'b0;
      n = 0;
      tick(1);
      while (!i_scl && n < 5000) begin
         tick(1);
         n++;
      end
      tick(7);
      s = i_sda;
      o_scl_low <= 1'b1;
   endtask
   task automatic start_c();
      o_sda_low <= 1'b1;
      tick(8);
      o_scl_low <= 1'b1;
   endtask
   task automatic stop_c();
      tick(2);
      o_sda_low <= 1'b1;
      tick(6);
      o_scl_low <= 1'b0;
      tick(12);
      o_sda_low <= 1'b0;
      tick(16);
   endtask
   // Fewer than 8 bits leaves the byte unfinished, no acknowledge slot
   task automatic write_bits(input logic [7:0] b, input int n, output logic ack);
      logic s;
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) bit_x(b[i], s);
      if (n == 8) begin
         bit_x(1'b1, s);
         ack = !s;
      end
   endtask
   // Bits cleared in keep are pulled low by this model, like a competing sender
   task automatic read_byte(input logic m_ack, input logic [7:0] keep, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(keep[i], d[i]);
      bit_x(!m_ack, s);
   endtask
endmodule // ias_bus_master

// ===== verif/ias_slave_core_sva.sv
// Checker for the slave byte engine, watching the top ports only.
// Assumes it is bound from the bench top; one clock domain.
`timescale 1ns/100ps
module ias_slave_core_sva
   import ias_pkg::*;
(
   // Clock and reset
   input wire logic                  i_clock,
   input wire logic                  i_resetn,
   // Register port
   input wire ias_pkg::ias_reg_req_t i_reg,
   input wire logic [7:0]            o_rdata,
   // Bus pins and interrupt
   input wire logic                  i_scl,
   input wire logic                  o_scl_out,
   input wire logic                  o_scl_oe_n,
   input wire logic                  i_sda,
   input wire logic                  o_sda_out,
   input wire logic                  o_sda_oe_n,
   input wire logic                  o_irq
);
   logic [IRQ_W-1:0] mask_ff;
   logic             en_ff;
   wire logic        wr_ctrl = i_reg.wr && i_reg.addr == OFS_CTRL;
   wire logic        wr_mask = i_reg.wr && i_reg.addr == OFS_IRQ_MASK;

   // Shadow copies of what software wrote, so outputs can be tied to them
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_ff <= IRQ_RST;
         en_ff   <= 1'b0;
      end else begin
         if (wr_mask) mask_ff <= i_reg.wdata[IRQ_W-1:0];
         if (wr_ctrl) en_ff <= i_reg.wdata[CTRL_EN_BIT];
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   sequence s_status_read;
      i_reg.rd && i_reg.addr == OFS_STATUS;
   endsequence
   sequence s_flag_clear;
      wr_ctrl && !i_reg.wdata[CTRL_EVT_BIT];
   endsequence

   a_stat_low_zero: assert property (s_status_read |=> o_rdata[2:0] == 3'h0)
      else $error("status low bits not zero");
   a_rdata_idle: assert property (!i_reg.rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_pins_drive_low: assert property (!o_scl_out && !o_sda_out)
      else $error("pin output level not low");
   a_sda_edge_safe: assert property ($changed(o_sda_oe_n) |-> !i_scl)
      else $error("sda drive changed while scl high");
   a_scl_hold_flag: assert property (!o_scl_oe_n && !wr_ctrl && !$past(wr_ctrl) |=> !o_scl_oe_n)
      else $error("scl released without software clear");
   a_scl_free_clear: assert property (!o_scl_oe_n ##0 s_flag_clear |=> o_scl_oe_n)
      else $error("scl still held after flag clear");
   a_irq_on_event: assert property ($fell(o_scl_oe_n) && mask_ff[IRQ_EVT_BIT] |-> ##[0:2] o_irq)
      else $error("no interrupt on event");
   a_irq_masked: assert property (mask_ff == IRQ_RST && $past(mask_ff) == IRQ_RST |-> !o_irq)
      else $error("interrupt while fully masked");
   a_quiet_disabled: assert property (!en_ff && !$past(en_ff) |-> o_sda_oe_n && o_scl_oe_n)
      else $error("bus driven while disabled");
endmodule // ias_slave_core_sva

// ===== verif/ias_slave_core_tb.sv
// Self-checking bench for the slave byte engine with a bus master model.
// Assumes pull-ups on both wires; checker bound at the foot of this file.
`timescale 1ns/100ps
module ias_slave_core_tb;
   import ias_pkg::*;
   localparam logic [7:0] C_EN  = 8'h01 << CTRL_EN_BIT;
   localparam logic [7:0] C_ON  = C_EN | (8'h01 << CTRL_AA_BIT);
   localparam logic [7:0] C_REL = C_ON | (8'h01 << CTRL_REL_BIT);
   localparam logic [6:0] OWN_A = 7'h5a;
   logic         clk;
   logic         rstn;
   ias_reg_req_t req;
   logic [7:0]   rdata;
   logic         scl_oe_n;
   logic         sda_oe_n;
   logic         irq;
   logic         m_scl_low;
   logic         m_sda_low;
   logic [31:0]  seed = 32'h0000_9c4d;
   int           n_errors = 0;
   int           n_tests = 0;
   wire logic    scl_w = !(m_scl_low || !scl_oe_n);
   wire logic    sda_w = !(m_sda_low || !sda_oe_n);

   ias_slave_core i_dut (.i_clock(clk), .i_resetn(rstn), .i_reg(req), .o_rdata(rdata),
      .i_scl(scl_w), .o_scl_out(), .o_scl_oe_n(scl_oe_n), .i_sda(sda_w), .o_sda_out(),
      .o_sda_oe_n(sda_oe_n), .o_irq(irq));
   ias_bus_master i_mst (.i_clock(clk), .i_scl(scl_w), .i_sda(sda_w),
      .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Wired-and of two senders: a low from either one wins the bit
   function automatic logic [7:0] bus_byte(input logic [7:0] a, input logic [7:0] b);
      return a & b;
   endfunction
   task automatic nxt(output logic [7:0] b);
      seed = lfsr(seed);
      b = seed[7:0];
   endtask
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      check(name, exp, rdata);
   endtask
   // Waits for the stretch that marks an event, then reads the code
   task automatic wait_evt(input logic [7:0] code);
      int n;
      n = 0;
      while (scl_oe_n !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      rd_chk("status", OFS_STATUS, code);
   endtask
   task automatic wbyte(input logic [7:0] b, input logic exp_ack, input logic [7:0] code);
      logic ack;
      i_mst.write_bits(b, 8, ack);
      check("ack", {7'h00, exp_ack}, {7'h00, ack});
      wait_evt(code);
   endtask
   task automatic addr(input logic [7:0] a, input logic exp_ack, input logic [7:0] code);
      i_mst.start_c();
      wbyte(a, exp_ack, code);
   endtask
   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // About 3500 cycles of traffic are expected
   initial begin
      #200us;
      n_errors++;
      end_of_test();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] x;
      logic [7:0] m;
      logic       ack;
      req = '0;
      rstn = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd_chk("data", OFS_DATA, DATA_RST);
      rd_chk("status", OFS_STATUS, ST_IDLE);
      reg_wr(OFS_STATUS, 8'h55);
      rd_chk("status", OFS_STATUS, ST_IDLE);
      rd_chk("unmapped", 8'hbe, 8'h00);
      reg_wr(OFS_OWN, {OWN_A, 1'b1});
      reg_wr(OFS_IRQ_MASK, 8'h07);
      reg_wr(OFS_CTRL, C_EN);
      addr({OWN_A, 1'b0}, 1'b0, ST_IDLE);
      check("irq", 8'h00, {7'h00, irq});
      i_mst.stop_c();
      addr(8'h00, 1'b0, ST_IDLE);
      i_mst.stop_c();
      reg_wr(OFS_CTRL, C_ON);
      addr({OWN_A, 1'b0}, 1'b1, ST_SLA_W);
      check("irq", 8'h01, {7'h00, irq});
      reg_wr(OFS_IRQ_STAT, 8'h01);
      rd_chk("irq stat", OFS_IRQ_STAT, 8'h00);
      repeat (4) begin
         nxt(d);
         reg_wr(OFS_CTRL, C_ON);
         wbyte(d, 1'b1, ST_RX_ACK);
         repeat (20) @(posedge clk);
         rd_chk("rx data", OFS_DATA, d);
      end
      nxt(d);
      reg_wr(OFS_CTRL, C_EN);
      wbyte(d, 1'b0, ST_RX_NACK);
      reg_wr(OFS_CTRL, C_ON);
      wbyte(~d, 1'b0, ST_IDLE);
      i_mst.stop_c();
      addr(8'h00, 1'b1, ST_GC);
      reg_wr(OFS_CTRL, C_ON);
      wbyte(d, 1'b1, ST_GC_RX_ACK);
      reg_wr(OFS_CTRL, C_ON);
      i_mst.stop_c();
      wait_evt(ST_STOP);
      reg_wr(OFS_CTRL, C_ON);
      addr({OWN_A, 1'b1}, 1'b1, ST_SLA_R);
      nxt(x);
      reg_wr(OFS_DATA, x);
      reg_wr(OFS_CTRL, C_ON);
      i_mst.read_byte(1'b1, 8'hff, d);
      check("tx byte", x, d);
      wait_evt(ST_TX_ACK);
      rd_chk("tx data", OFS_DATA, x);
      nxt(x);
      reg_wr(OFS_DATA, x);
      reg_wr(OFS_CTRL, C_EN);
      i_mst.read_byte(1'b1, 8'hff, d);
      check("last byte", x, d);
      wait_evt(ST_TX_LAST);
      reg_wr(OFS_CTRL, C_ON);
      i_mst.read_byte(1'b0, 8'hff, d);
      check("after last", 8'hff, d);
      i_mst.stop_c();
      addr({OWN_A, 1'b1}, 1'b1, ST_SLA_R);
      nxt(x);
      nxt(m);
      reg_wr(OFS_DATA, x);
      reg_wr(OFS_CTRL, C_ON);
      i_mst.read_byte(1'b0, m, d);
      check("bus byte", bus_byte(x, m), d);
      wait_evt(ST_TX_NACK);
      rd_chk("lost data", OFS_DATA, bus_byte(x, m));
      reg_wr(OFS_CTRL, C_ON);
      i_mst.stop_c();
      addr({OWN_A, 1'b0}, 1'b1, ST_SLA_W);
      reg_wr(OFS_IRQ_STAT, 8'h07);
      reg_wr(OFS_CTRL, C_ON);
      i_mst.write_bits(8'ha5, 3, ack);
      i_mst.stop_c();
      wait_evt(ST_BUS_ERR);
      rd_chk("irq stat", OFS_IRQ_STAT, (8'h01 << IRQ_EVT_BIT) | (8'h01 << IRQ_ERR_BIT));
      reg_wr(OFS_CTRL, C_REL);
      rd_chk("status", OFS_STATUS, ST_IDLE);
      repeat (20) @(posedge clk);
      check("sda free", 8'h03, {6'h00, sda_oe_n, scl_oe_n});
      reg_wr(OFS_IRQ_MASK, 8'h00);
      repeat (4) @(posedge clk);
      check("irq", 8'h00, {7'h00, irq});
      end_of_test();
   end
endmodule // ias_slave_core_tb

bind ias_slave_core ias_slave_core_sva i_sva (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_reg(i_reg), .o_rdata(o_rdata), .i_scl(i_scl), .o_scl_out(o_scl_out),
   .o_scl_oe_n(o_scl_oe_n), .i_sda(i_sda), .o_sda_out(o_sda_out),
   .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));
